//--- logic/port_m_defines.vh
// constants for the port m pin configuration block
`ifndef PORT_M_DEFINES_VH
`define PORT_M_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PM_OFS_OUTPUT_LATCH   12'h000
`define PM_OFS_PIN_LEVEL      12'h004
`define PM_OFS_PIN_DIRECTION  12'h008
`define PM_OFS_DRIVE_SELECT   12'h00c
`define PM_OFS_PULL_ENABLE    12'h010
`define PM_OFS_PULL_POLARITY  12'h014
`define PM_OFS_OPEN_DRAIN     12'h018

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define PM_PIN_COUNT          6
`define PM_IMPL_MASK          8'h3f
`define PM_SPI_PIN_LO         2
`define PM_SPI_PIN_HI         5
`define PM_CAN_TX_PIN         1
`define PM_CAN_RX_PIN         0
`define PM_RESET_CONFIG       8'h00

`endif

//--- logic/port_m_pin_config.v
// port m pin configuration: direction, drive, pull and apb registers
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "port_m_defines.vh"
`default_nettype none

module port_m_pin_config
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        spi_enable,
	input  wire [5:2]  spi_dir_out,
	input  wire [5:2]  spi_data_out,
	input  wire        can_enable,
	input  wire        can_transmit_data,
	input  wire [5:0]  pin_in,
	output reg  [5:0]  pin_out,
	output reg  [5:0]  pin_oe_n,
	output reg  [5:0]  pin_level,
	output reg  [5:0]  pin_reduced_drive,
	output reg  [5:0]  pin_pull_enable,
	output reg  [5:0]  pin_pull_down
);

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
// bits 7..6 are not built, so only the low six bits of these matter
localparam [7:0] impl_mask    = `PM_IMPL_MASK;
localparam [7:0] reset_config = `PM_RESET_CONFIG;

function [5:0] impl_bits;
	input [31:0] data;
	begin
		impl_bits = data[5:0] & impl_mask[5:0];
	end
endfunction

function [31:0] read_word;
	input [5:0] data;
	begin
		read_word = {26'h0, data};
	end
endfunction

// output bits read back the latch, input bits the synchronised pad
function [5:0] data_view;
	input [5:0] latch;
	input [5:0] pad;
	input [5:0] dir;
	begin
		data_view = (latch & dir) | (pad & ~dir);
	end
endfunction

// one decoder serves writes and the error flag, so they cannot disagree
function reg_mapped;
	input [11:0] addr;
	begin
		case (addr)
			`PM_OFS_OUTPUT_LATCH,
			`PM_OFS_PIN_LEVEL,
			`PM_OFS_PIN_DIRECTION,
			`PM_OFS_DRIVE_SELECT,
			`PM_OFS_PULL_ENABLE,
			`PM_OFS_PULL_POLARITY,
			`PM_OFS_OPEN_DRAIN:
				reg_mapped = 1'b1;
			default:
				reg_mapped = 1'b0;
		endcase
	end
endfunction

// ----------------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------------
reg  [5:0] port_output_latch;
reg  [5:0] pin_direction;
reg  [5:0] drive_strength_select;
reg  [5:0] pull_device_enable;
reg  [5:0] pull_polarity_select;
reg  [5:0] open_drain_select;

// pins are asynchronous to pclk; only pin_sync2 is read by logic
reg  [5:0] pin_sync1;
reg  [5:0] pin_sync2;

// ----------------------------------------------------------------------
// apb handshake
// ----------------------------------------------------------------------

wire       setup_phase;
wire       write_access;

assign setup_phase  = psel & ~penable;
assign write_access = psel & penable & pwrite & pready
	& reg_mapped(paddr);

// ----------------------------------------------------------------------
// pin input synchroniser
// ----------------------------------------------------------------------

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pin_sync1 <= 6'h00;
		pin_sync2 <= 6'h00;
	end
	else
	begin
		pin_sync1 <= pin_in;
		pin_sync2 <= pin_sync1;
	end
end

// writes land in the access cycle, the only edge where psel and penable are both high
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		port_output_latch     <= reset_config[5:0];
		pin_direction         <= reset_config[5:0];
		drive_strength_select <= reset_config[5:0];
		pull_device_enable    <= reset_config[5:0];
		pull_polarity_select  <= reset_config[5:0];
		open_drain_select     <= reset_config[5:0];
	end
	else if (write_access)
	begin
		case (paddr)
			`PM_OFS_OUTPUT_LATCH:
				port_output_latch <= impl_bits(pwdata);
			`PM_OFS_PIN_DIRECTION:
				pin_direction <= impl_bits(pwdata);
			`PM_OFS_DRIVE_SELECT:
				drive_strength_select <= impl_bits(pwdata);
			`PM_OFS_PULL_ENABLE:
				pull_device_enable <= impl_bits(pwdata);
			`PM_OFS_PULL_POLARITY:
				pull_polarity_select <= impl_bits(pwdata);
			`PM_OFS_OPEN_DRAIN:
				open_drain_select <= impl_bits(pwdata);
			default:
				port_output_latch <= port_output_latch;
		endcase
	end
end

// ----------------------------------------------------------------------
// pin ownership and effective direction
// ----------------------------------------------------------------------
reg  [5:0] next_dir_out;
reg  [5:0] next_data;

// overrides only steer the pin; the stored direction bits stay as written
always @*
begin
	next_dir_out = pin_direction;
	next_data    = port_output_latch;
	if (spi_enable)
	begin
		next_dir_out[5:2] = spi_dir_out;
		next_data[5:2]    = spi_data_out;
	end
	if (can_enable)
	begin
		next_dir_out[`PM_CAN_TX_PIN] = 1'b1;
		next_data[`PM_CAN_TX_PIN]    = can_transmit_data;
		next_dir_out[`PM_CAN_RX_PIN] = 1'b0;
	end
end

// ----------------------------------------------------------------------
// output buffer, drive strength and pull device
// ----------------------------------------------------------------------
reg  [5:0] next_oe_n;
reg  [5:0] next_reduced;
reg  [5:0] next_pull_en;
reg  [5:0] next_pull_down;

// wired-and releases a one so other drivers on the net can win
always @*
begin
	next_oe_n = ~(next_dir_out & (~open_drain_select | ~next_data));
end

// whichever function owns the pin, the drive bit applies while its effective direction is output, even when open drain releases it
always @*
begin
	next_reduced = drive_strength_select & next_dir_out;
end

// can receive cannot be pulled down while the controller is active
always @*
begin
	next_pull_en   = pull_device_enable
		& (~next_dir_out | open_drain_select);
	next_pull_down = pull_polarity_select;
	if (can_enable & pull_polarity_select[`PM_CAN_RX_PIN])
		next_pull_en[`PM_CAN_RX_PIN] = 1'b0;
end

always @(posedge pclk or negedge presetn)
begin
	// pads leave reset released, so nothing fights the board
	if (!presetn)
	begin
		pin_out           <= 6'h00;
		pin_oe_n          <= 6'h3f;
		pin_level         <= 6'h00;
		pin_reduced_drive <= 6'h00;
		pin_pull_enable   <= 6'h00;
		pin_pull_down     <= 6'h00;
	end
	else
	begin
		pin_out           <= next_data;
		pin_oe_n          <= next_oe_n;
		pin_level         <= pin_sync2;
		pin_reduced_drive <= next_reduced;
		pin_pull_enable   <= next_pull_en;
		pin_pull_down     <= next_pull_down;
	end
end

// ----------------------------------------------------------------------
// apb read path
// ----------------------------------------------------------------------
reg  [31:0] next_rdata;
reg         next_err;

// data register shows the latch for output bits, the pin for inputs
always @*
begin
	next_rdata = 32'h00000000;
	next_err   = ~reg_mapped(paddr);
	case (paddr)
		`PM_OFS_OUTPUT_LATCH:
			next_rdata = read_word(data_view(port_output_latch,
				pin_sync2, pin_direction));
		`PM_OFS_PIN_LEVEL:
			next_rdata = read_word(pin_sync2);
		`PM_OFS_PIN_DIRECTION:
			next_rdata = read_word(pin_direction);
		`PM_OFS_DRIVE_SELECT:
			next_rdata = read_word(drive_strength_select);
		`PM_OFS_PULL_ENABLE:
			next_rdata = read_word(pull_device_enable);
		`PM_OFS_PULL_POLARITY:
			next_rdata = read_word(pull_polarity_select);
		`PM_OFS_OPEN_DRAIN:
			next_rdata = read_word(open_drain_select);
		default:
			next_rdata = 32'h00000000;
	endcase
end

// answer is prepared in the setup cycle so the access phase needs no wait
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		prdata  <= 32'h00000000;
		pready  <= 1'b0;
		pslverr <= 1'b0;
	end
	else
	begin
		pready <= 1'b1;
		if (setup_phase)
		begin
			prdata  <= pwrite ? 32'h00000000 : next_rdata;
			pslverr <= next_err;
		end
	end
end

endmodule

`default_nettype wire

//--- testbench/port_m_checker.sv
// assertions on the port m pin configuration ports
`timescale 1ns/100ps
`default_nettype none
module port_m_checker
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        spi_enable,
	input wire logic [5:2]  spi_dir_out,
	input wire logic [5:2]  spi_data_out,
	input wire logic        can_enable,
	input wire logic        can_transmit_data,
	input wire logic [5:0]  pin_in,
	input wire logic [5:0]  pin_oe_n,
	input wire logic [5:0]  pin_level,
	input wire logic [5:0]  pin_reduced_drive,
	input wire logic [5:0]  pin_pull_enable,
	input wire logic [5:0]  pin_pull_down
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_hi; prdata[31:6] == 26'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_rdy; $past(presetn) |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("not ready");
	property p_tx; can_enable && !can_transmit_data |=> !pin_oe_n[1]; endproperty
	a_tx: assert property (p_tx) else $error("pin 1 not driven");
	property p_rx; can_enable |=> pin_oe_n[0] && !pin_reduced_drive[0];
	endproperty
	a_rx: assert property (p_rx) else $error("pin 0 not input");
	property p_si; spi_enable && !spi_dir_out[2] |=> pin_oe_n[2]; endproperty
	a_si: assert property (p_si) else $error("pin 2 driven");
	property p_so;
		spi_enable && spi_dir_out[3] && !spi_data_out[3] |=> !pin_oe_n[3];
	endproperty
	a_so: assert property (p_so) else $error("pin 3 not driven");
	property p_rd; spi_enable && !spi_dir_out[4] |=> !pin_reduced_drive[4];
	endproperty
	a_rd: assert property (p_rd) else $error("drive on input");
	property p_pd; $past(can_enable) && pin_pull_down[0] |-> !pin_pull_enable[0];
	endproperty
	a_pd: assert property (p_pd) else $error("receive pull-down on");
	property p_lv; $past(presetn, 3) |-> pin_level == $past(pin_in, 3);
	endproperty
	a_lv: assert property (p_lv) else $error("pin level late");
	c_can: cover property (can_enable && can_transmit_data);
	c_spi: cover property (spi_enable && spi_dir_out == 4'hf);
	c_pd: cover property (can_enable && pin_pull_down[0]);
endmodule
bind port_m_pin_config port_m_checker chk (.*);
`default_nettype wire

//--- testbench/pin_partner.sv
// external pad model: drivers, pull devices and floating pads
`timescale 1ns/100ps
`default_nettype none
module pin_partner
(
	input  wire logic       pclk,
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe_n,
	input  wire logic [5:0] pin_pull_enable,
	input  wire logic [5:0] pin_pull_down,
	output var  logic [5:0] pin_in
);
	logic [5:0] last = 6'h00;
	// a floating pad toggles so a stale level is never taken as driven
	always @(posedge pclk)
		last <= pin_in;
	always_comb
		pin_in = (~pin_oe_n & pin_out)
			| (pin_oe_n & pin_pull_enable & ~pin_pull_down)
			| (pin_oe_n & ~pin_pull_enable & ~last);
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the port m pin configuration block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic        pready, pslverr, e, spi_enable = 0;
	logic        can_enable = 0, can_transmit_data = 0;
	logic [5:2]  spi_dir_out = 0, spi_data_out = 0;
	logic [5:0]  pin_in, pin_out, pin_oe_n, pin_level, pin_reduced_drive;
	logic [5:0]  pin_pull_enable, pin_pull_down, ed, ov, oe, pe, pin, m, x, k;
	logic [5:0]  r [7] = '{default: 6'h00};
	logic [15:0] s = 16'h0053;
	int          n_errors = 0, n_tests = 0, i, j;
	port_m_pin_config uut (.*);
	pin_partner pp (.*);
	always #2.5 pclk = ~pclk;
	function logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task check_all;
		ed = r[2];
		ov = r[0];
		if (spi_enable)
			{ed[5:2], ov[5:2]} = {spi_dir_out, spi_data_out};
		if (can_enable)
			{ed[1:0], ov[1]} = {2'b10, can_transmit_data};
		oe = ~(ed & ~(r[6] & ov));
		pe = r[4] & (~ed | r[6]) & ~{5'h00, can_enable & r[5][0]};
		pin = (~oe & ov) | (oe & pe & ~r[5]);
		k = ~oe | pe;
		chk(pin_oe_n, oe);
		chk(pin_out & ~oe, ov & ~oe);
		chk(pin_reduced_drive, r[3] & ed);
		chk(pin_pull_enable, pe);
		chk(pin_pull_down, r[5]);
		for (j = 0; j < 8; j++)
		begin
			apb(1'b0, 12'(j * 4), 32'h0);
			chk(e, j == 7);
			x = j == 0 ? (r[0] & r[2]) | (pin & ~r[2]) : j == 1 ? pin
				: j < 7 ? r[j % 7] : 6'h00;
			m = j == 0 ? r[2] | k : j == 1 ? k : 6'h3f;
			chk(q & {26'h3ffffff, m}, {26'h0, x & m});
		end
	endtask
	task results;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#60000;
		n_errors++;
		results;
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		check_all;
		for (i = 0; i < 24; i++)
		begin
			for (j = 0; j < 8; j++)
			begin
				s = lfsr(s);
				apb(1'b1, 12'(j * 4), {s, s});
				chk(e, j == 7);
				if (j != 1 && j < 7)
					r[j] = s[5:0];
			end
			s = lfsr(s);
			{spi_enable, can_enable, can_transmit_data} <= s[10:8];
			{spi_dir_out, spi_data_out} <= s[7:0];
			repeat (6) @(posedge pclk);
			check_all;
		end
		// a reset in mid-run must clear every stored bit again
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		r = '{default: 6'h00};
		repeat (6) @(posedge pclk);
		check_all;
		results;
	end
endmodule
`default_nettype wire
